// ---- design/ftsf_cfg.svh ----
`ifndef FTSF_CFG_SVH
`define FTSF_CFG_SVH

// ----------------------------------------
// Default offsets, picked by load/sel1/sel0
// ----------------------------------------
`define FTSF_OFS_W     17
`define FTSF_OFS_LHL   17'h03fff
`define FTSF_OFS_LLH   17'h01fff
`define FTSF_OFS_LHH   17'h00fff
`define FTSF_OFS_HHL   17'h007ff
`define FTSF_OFS_HLL   17'h003ff
`define FTSF_OFS_HLH   17'h001ff
`define FTSF_OFS_HHH   17'h000ff
`define FTSF_OFS_LLL   17'h0007f

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define FTSF_FALL_EDGES 3
`define FTSF_RST_LOW    1'h0
`define FTSF_RST_HIGH   1'h1

`endif

// ---- design/ftsf_core.sv ----
// The implementer's own choices: the placing of the registers.
`timescale 1ns/100ps
`include "ftsf_cfg.svh"

// Behaviour
// - Master reset samples the select pin; low standard, high fall-through; then fixed.
// - Fall-through: first word into empty FIFO appears after three read edges.
// - Word captured on each write clock rising edge while write enable is low.
// - Standard: empty flag goes high once the first word is written.
// - Standard: almost-empty goes high when count reaches empty offset plus one.
// - Standard: half-full goes low at half depth plus one words.
// - Standard: almost-full goes low at depth minus full offset words.
// - Standard: full flag low at depth words; writes blocked while full.
// - Standard: first read from full raises full flag; others release later.
// - Standard: almost-empty goes low when exactly n words remain.
// - Standard: empty flag low after last read; read enable ignored when empty.
// - Standard: empty and full flags pass two register stages.
// - Fall-through: output ready goes low after first word into empty FIFO.
// - Fall-through: almost-empty goes high at empty offset plus two words.
// - Fall-through: half-full goes low at half depth plus two words.
// - Fall-through: almost-full goes low at depth plus one minus full offset.
// - Fall-through: input ready goes high, blocking writes, at depth plus one.
// - Fall-through: first read from full drives input ready low again.
// - Fall-through: almost-empty goes low when n plus one words remain.
// - Fall-through: output ready high after last read; read enable ignored.
// - Fall-through: output ready three stages, input ready two stages.
// - Master reset loads one of eight default offset pairs from the pins.

module ftsf_core #(
	parameter int DW    = 36,
	parameter int DEPTH = 65536
) (
	// Clock, reset, enable
	input  wire logic          MCLK,
	input  wire logic          RST_N,
	input  wire logic          CE,
	// Write side pins
	input  wire logic          WRITE_CLOCK,
	input  wire logic          WRITE_ENABLE_N,
	input  wire logic [DW-1:0] DATA_IN_BUS,
	// Read side pins
	input  wire logic          READ_CLOCK,
	input  wire logic          READ_ENABLE_N,
	// Master reset straps
	input  wire logic          MASTER_RESET_N,
	input  wire logic          FALL_THROUGH_SELECT_SERIAL_IN,
	input  wire logic          OFFSET_LOAD_N,
	input  wire logic          DEFAULT_OFFSET_SEL1,
	input  wire logic          DEFAULT_OFFSET_SEL0,
	// Data out
	output logic      [DW-1:0] DATA_OUT_BUS,
	// Status flags
	output logic               EMPTY_FLAG_N,
	output logic               FULL_FLAG_N,
	output logic               OUTPUT_READY_N,
	output logic               INPUT_READY_N,
	output logic               ALMOST_EMPTY_FLAG_N,
	output logic               ALMOST_FULL_FLAG_N,
	output logic               HALF_FULL_FLAG_N,
	output logic               FALL_THROUGH_MODE
);

	localparam int AW = $clog2(DEPTH);
	localparam int TW = AW + 2;
	localparam int SW = DW + 9;
	localparam int OW = `FTSF_OFS_W;

	localparam logic [TW-1:0] DEP_T  = TW'(DEPTH);
	localparam logic [TW-1:0] HALF_T = TW'(DEPTH / 2);
	localparam logic [TW-1:0] ONE_T  = TW'(1);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [OW-1:0] dflt_ofs(
		input logic ld_n,
		input logic s1,
		input logic s0
	);
		logic [OW-1:0] v;
		v = `FTSF_OFS_LLL;
		case ({ld_n, s1, s0})
			3'h2: v = `FTSF_OFS_LHL;
			3'h1: v = `FTSF_OFS_LLH;
			3'h3: v = `FTSF_OFS_LHH;
			3'h6: v = `FTSF_OFS_HHL;
			3'h4: v = `FTSF_OFS_HLL;
			3'h5: v = `FTSF_OFS_HLH;
			3'h7: v = `FTSF_OFS_HHH;
			default: v = `FTSF_OFS_LLL;
		endcase
		return v;
	endfunction : dflt_ofs

	function automatic logic reached(
		input logic [TW-1:0] cnt,
		input logic [TW-1:0] lim
	);
		return cnt >= lim;
	endfunction : reached

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] sy1;
	logic [SW-1:0] sy2;
	logic [SW-1:0] sy3;
	logic [SW-1:0] acc;
	logic [SW-1:0] next_acc;

	assign pin_raw = {DATA_IN_BUS, WRITE_CLOCK, READ_CLOCK,
		WRITE_ENABLE_N, READ_ENABLE_N, MASTER_RESET_N,
		FALL_THROUGH_SELECT_SERIAL_IN, OFFSET_LOAD_N,
		DEFAULT_OFFSET_SEL1, DEFAULT_OFFSET_SEL0};

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sy1 <= '0;
			sy2 <= '0;
			sy3 <= '0;
		end else if (CE) begin
			sy1 <= pin_raw;
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	// Change accepted once stages two and three agree
	always_comb begin
		for (int i = 0; i < SW; i++) begin
			next_acc[i] = (sy2[i] == sy3[i]) ? sy2[i] : acc[i];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			acc <= '0;
		end else if (CE) begin
			acc <= next_acc;
		end
	end

	ftsf_pkg::ftsf_pins_t pc;
	ftsf_pkg::ftsf_pins_t pn;
	logic [DW-1:0]        din;

	assign pc  = acc[8:0];
	assign pn  = next_acc[8:0];
	assign din = acc[SW-1:9];

	logic wr_evt;
	logic rd_evt;
	logic mrs_act;

	assign wr_evt  = pn.wclk & ~pc.wclk;
	assign rd_evt  = pn.rclk & ~pc.rclk;
	assign mrs_act = ~pc.mrs_n;

	// ----------------------------------------
	// Master reset straps
	// ----------------------------------------
	ftsf_pkg::ftsf_mode_t mode;
	logic                 fw;
	logic [OW-1:0]        ofs_empty;
	logic [OW-1:0]        ofs_full;

	assign fw = (mode == ftsf_pkg::FTSF_FALL_THROUGH);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mode <= ftsf_pkg::FTSF_STANDARD;
		end else if (CE && mrs_act) begin
			mode <= pc.fts ? ftsf_pkg::FTSF_FALL_THROUGH
				: ftsf_pkg::FTSF_STANDARD;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ofs_empty <= `FTSF_OFS_LLL;
			ofs_full  <= `FTSF_OFS_LLL;
		end else if (CE && mrs_act) begin
			ofs_empty <= dflt_ofs(pc.ld_n, pc.sel1, pc.sel0);
			ofs_full  <= dflt_ofs(pc.ld_n, pc.sel1, pc.sel0);
		end
	end

	// ----------------------------------------
	// Storage and pointers
	// ----------------------------------------
	logic [DW-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   mem_cnt;
	logic          out_valid;
	logic [TW-1:0] tot;
	logic          mem_full;
	logic          mem_some;
	logic          wr_ok;
	logic          fall_load;
	logic          adv;
	logic          pop;
	logic [2:0]    or_p;

	assign mem_full = (mem_cnt == (AW+1)'(DEPTH));
	assign mem_some = (mem_cnt != '0);
	assign tot      = TW'(mem_cnt) + (fw ? TW'(out_valid) : '0);

	// Write blocked while memory full
	assign wr_ok = wr_evt & ~pc.wen_n & ~mrs_act & ~mem_full;

	// Fall-through load on the third read edge
	assign fall_load = fw & rd_evt & ~out_valid & or_p[1] & mem_some & ~mrs_act;
	assign adv       = fw & rd_evt & ~pc.ren_n & out_valid & ~mrs_act;

	// Reads while empty are ignored
	assign pop = (~fw & rd_evt & ~pc.ren_n & mem_some & ~mrs_act)
		| fall_load | (adv & mem_some);

	always_ff @(posedge MCLK) begin
		if (CE && wr_ok) begin
			mem[wr_ptr] <= din;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr <= '0;
		end else if (CE) begin
			if (mrs_act) begin
				wr_ptr <= '0;
			end else if (wr_ok) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_ptr <= '0;
		end else if (CE) begin
			if (mrs_act) begin
				rd_ptr <= '0;
			end else if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// One count, both events applied in the same cycle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mem_cnt <= '0;
		end else if (CE) begin
			if (mrs_act) begin
				mem_cnt <= '0;
			end else if (wr_ok && !pop) begin
				mem_cnt <= mem_cnt + 1'b1;
			end else if (pop && !wr_ok) begin
				mem_cnt <= mem_cnt - 1'b1;
			end
		end
	end

	// Output register word
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			out_valid <= 1'b0;
		end else if (CE) begin
			if (mrs_act) begin
				out_valid <= 1'b0;
			end else if (fall_load) begin
				out_valid <= 1'b1;
			end else if (adv) begin
				out_valid <= mem_some;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			DATA_OUT_BUS <= '0;
		end else if (CE) begin
			if (mrs_act) begin
				DATA_OUT_BUS <= '0;
			end else if (pop) begin
				DATA_OUT_BUS <= mem[rd_ptr];
			end
		end
	end

	// ----------------------------------------
	// Empty and full, standard mode
	// ----------------------------------------
	logic ef1;
	logic ff1;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ef1          <= `FTSF_RST_LOW;
			EMPTY_FLAG_N <= `FTSF_RST_LOW;
		end else if (CE) begin
			if (mrs_act) begin
				ef1          <= `FTSF_RST_LOW;
				EMPTY_FLAG_N <= pc.fts;
			end else if (rd_evt) begin
				ef1          <= mem_some;
				EMPTY_FLAG_N <= fw | ef1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ff1         <= `FTSF_RST_HIGH;
			FULL_FLAG_N <= `FTSF_RST_HIGH;
		end else if (CE) begin
			if (mrs_act) begin
				ff1         <= `FTSF_RST_HIGH;
				FULL_FLAG_N <= `FTSF_RST_HIGH;
			end else if (wr_evt) begin
				ff1         <= ~mem_full;
				FULL_FLAG_N <= fw | ff1;
			end
		end
	end

	// ----------------------------------------
	// Output and input ready, fall-through
	// ----------------------------------------
	logic ir1;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			or_p           <= '0;
			OUTPUT_READY_N <= `FTSF_RST_HIGH;
		end else if (CE) begin
			if (mrs_act || (adv && !mem_some)) begin
				or_p           <= '0;
				OUTPUT_READY_N <= `FTSF_RST_HIGH;
			end else if (rd_evt) begin
				or_p           <= {or_p[1:0], (tot != '0)};
				OUTPUT_READY_N <= ~fw | ~or_p[1];
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ir1           <= `FTSF_RST_LOW;
			INPUT_READY_N <= `FTSF_RST_LOW;
		end else if (CE) begin
			if (mrs_act) begin
				ir1           <= `FTSF_RST_LOW;
				INPUT_READY_N <= ~pc.fts;
			end else if (wr_evt) begin
				ir1           <= (tot == DEP_T + ONE_T);
				INPUT_READY_N <= ~fw | ir1;
			end
		end
	end

	// ----------------------------------------
	// Programmable and half flags
	// ----------------------------------------
	logic [TW-1:0] lim_ae;
	logic [TW-1:0] lim_hf;
	logic [TW-1:0] lim_af;
	logic [TW-1:0] fw_t;

	assign fw_t   = TW'(fw);
	// Fall-through thresholds sit one word higher
	assign lim_ae = TW'(ofs_empty) + ONE_T + fw_t;
	assign lim_hf = HALF_T + ONE_T + fw_t;
	assign lim_af = DEP_T - TW'(ofs_full) + fw_t;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ALMOST_EMPTY_FLAG_N <= `FTSF_RST_LOW;
			HALF_FULL_FLAG_N    <= `FTSF_RST_HIGH;
			ALMOST_FULL_FLAG_N  <= `FTSF_RST_HIGH;
		end else if (CE) begin
			if (mrs_act) begin
				ALMOST_EMPTY_FLAG_N <= `FTSF_RST_LOW;
				HALF_FULL_FLAG_N    <= `FTSF_RST_HIGH;
				ALMOST_FULL_FLAG_N  <= `FTSF_RST_HIGH;
			end else begin
				ALMOST_EMPTY_FLAG_N <= reached(tot, lim_ae);
				HALF_FULL_FLAG_N    <= ~reached(tot, lim_hf);
				ALMOST_FULL_FLAG_N  <= ~reached(tot, lim_af);
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			FALL_THROUGH_MODE <= 1'b0;
		end else if (CE) begin
			FALL_THROUGH_MODE <= fw;
		end
	end

endmodule : ftsf_core

// ---- design/ftsf_pkg.sv ----
package ftsf_pkg;

	// ----------------------------------------
	// Control pins after the synchroniser
	// ----------------------------------------
	typedef struct packed {
		logic wclk;
		logic rclk;
		logic wen_n;
		logic ren_n;
		logic mrs_n;
		logic fts;
		logic ld_n;
		logic sel1;
		logic sel0;
	} ftsf_pins_t;

	// ----------------------------------------
	// Timing mode latched at master reset
	// ----------------------------------------
	typedef enum logic {
		FTSF_STANDARD,
		FTSF_FALL_THROUGH
	} ftsf_mode_t;

endpackage : ftsf_pkg

// ---- verif/ftsf_checker.sv ----
`timescale 1ns/100ps

module ftsf_checker #(
	parameter int DW = 36
) (
	// Watched ports
	input wire logic          MCLK,
	input wire logic          RST_N,
	input wire logic          READ_ENABLE_N,
	input wire logic          MASTER_RESET_N,
	input wire logic [DW-1:0] DATA_OUT_BUS,
	input wire logic          EMPTY_FLAG_N,
	input wire logic          FULL_FLAG_N,
	input wire logic          OUTPUT_READY_N,
	input wire logic          INPUT_READY_N,
	input wire logic          ALMOST_EMPTY_FLAG_N,
	input wire logic          ALMOST_FULL_FLAG_N,
	input wire logic          HALF_FULL_FLAG_N,
	input wire logic          FALL_THROUGH_MODE
);
	logic [3:0] mrs_age;
	logic [3:0] ren_age;

	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// Saturating ages of master reset and read enable
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mrs_age <= 4'h0;
			ren_age <= 4'hf;
		end else begin
			mrs_age <= !MASTER_RESET_N ? 4'h0 : mrs_age + {3'h0, mrs_age != 4'hf};
			ren_age <= !READ_ENABLE_N ? 4'h0 : ren_age + {3'h0, ren_age != 4'hf};
		end
	end

	sequence s_std;
		mrs_age == 4'hf && !FALL_THROUGH_MODE;
	endsequence
	sequence s_fall_through_mode;
		mrs_age == 4'hf && FALL_THROUGH_MODE;
	endsequence

	a_mode_held: assert property (mrs_age == 4'hf |-> $stable(FALL_THROUGH_MODE))
		else $error("mode changed after master reset");
	a_std_empty_flags: assert property (s_std ##0 !EMPTY_FLAG_N |->
		!ALMOST_EMPTY_FLAG_N && HALF_FULL_FLAG_N && FULL_FLAG_N)
		else $error("empty flag with wrong levels");
	a_std_full_flags: assert property (s_std ##0 !FULL_FLAG_N |->
		!ALMOST_FULL_FLAG_N && !HALF_FULL_FLAG_N && ALMOST_EMPTY_FLAG_N)
		else $error("full flag with wrong levels");
	a_fw_blocked_flags: assert property (s_fall_through_mode ##0 INPUT_READY_N |->
		!ALMOST_FULL_FLAG_N && !HALF_FULL_FLAG_N)
		else $error("input ready high with wrong levels");
	a_fw_idle_flags: assert property (s_fall_through_mode ##0 OUTPUT_READY_N |->
		!ALMOST_EMPTY_FLAG_N && HALF_FULL_FLAG_N && !INPUT_READY_N)
		else $error("output ready high with wrong levels");
	a_fw_std_unused: assert property (s_fall_through_mode |-> EMPTY_FLAG_N && FULL_FLAG_N)
		else $error("standard flags active in fall-through");
	a_std_fw_unused: assert property (s_std |-> OUTPUT_READY_N && INPUT_READY_N)
		else $error("fall-through flags active in standard");
	a_std_read_data: assert property (s_std ##0 $changed(DATA_OUT_BUS) |->
		ren_age < 4'h8)
		else $error("data out moved without read enable");
	a_fw_data_still: assert property (s_fall_through_mode ##0 !OUTPUT_READY_N ##1
		!OUTPUT_READY_N && ren_age == 4'hf |-> $stable(DATA_OUT_BUS))
		else $error("head word moved without read");
endmodule : ftsf_checker

bind ftsf_core ftsf_checker #(.DW(DW)) ftsf_checker_i (
	.MCLK(MCLK), .RST_N(RST_N), .READ_ENABLE_N(READ_ENABLE_N),
	.MASTER_RESET_N(MASTER_RESET_N), .DATA_OUT_BUS(DATA_OUT_BUS),
	.EMPTY_FLAG_N(EMPTY_FLAG_N), .FULL_FLAG_N(FULL_FLAG_N),
	.OUTPUT_READY_N(OUTPUT_READY_N), .INPUT_READY_N(INPUT_READY_N),
	.ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N),
	.HALF_FULL_FLAG_N(HALF_FULL_FLAG_N), .FALL_THROUGH_MODE(FALL_THROUGH_MODE));

// ---- verif/ftsf_partner.sv ----
`timescale 1ns/100ps

module ftsf_partner #(
	parameter int DW = 36
) (
	// Clock and bench requests
	input  wire logic          mclk,
	input  wire logic          wr_req,
	input  wire logic          rd_req,
	input  wire logic [DW-1:0] wdata,
	// FIFO pins
	output logic               wclk,
	output logic               rclk,
	output logic               wen_n,
	output logic               ren_n,
	output logic      [DW-1:0] din
);
	logic [3:0] wph = 4'h0;
	logic [3:0] rph = 4'h3;

	initial begin
		wen_n = 1'h1;
		ren_n = 1'h1;
		din   = {DW{1'h0}};
	end

	// Free pin clocks, 10 MCLK period, read side skewed
	always @(posedge mclk) begin
		wph <= (wph == 4'h9) ? 4'h0 : wph + 4'h1;
		rph <= (rph == 4'h9) ? 4'h0 : rph + 4'h1;
	end
	assign wclk = (wph < 4'h5);
	assign rclk = (rph < 4'h5);

	// Change mid low phase, hold through the rise
	always @(posedge mclk) begin
		if (wph == 4'h7) begin
			wen_n <= !wr_req;
			din   <= wr_req ? wdata : ~din;
		end
		if (rph == 4'h7) begin
			ren_n <= !rd_req;
		end
	end
endmodule : ftsf_partner

// ---- verif/test_fifo_timing_mode_status_flags.sv ----
`timescale 1ns/100ps

module test_fifo_timing_mode_status_flags;
	localparam int DW = 36;
	localparam int D  = 256;

	logic          mclk   = 1'h0;
	logic          rst_n  = 1'h0;
	logic          wr_req = 1'h0;
	logic          rd_req = 1'h0;
	logic [DW-1:0] wdata  = 36'h0;
	logic          mrs_n  = 1'h1;
	logic          fts    = 1'h0;
	logic [2:0]    straps = 3'h0;
	logic          wclk, rclk, wen_n, ren_n, ef_n, ff_n, or_n, ir_n, ae_n, af_n, hf_n, fwm;
	logic [DW-1:0] din, dout;
	logic [31:0]   lfsr = 32'haa92aebd;
	logic [DW-1:0] q[$];
	int            bad_count = 0;
	int            comparisons = 0;
	int            cycles = 0;
	int            cnt = 0;
	int            ofs = 127;
	bit            fw = 0;

	ftsf_core #(.DW(DW), .DEPTH(D)) ftsf_core_i (
		.MCLK(mclk), .RST_N(rst_n), .CE(1'h1),
		.WRITE_CLOCK(wclk), .WRITE_ENABLE_N(wen_n), .DATA_IN_BUS(din),
		.READ_CLOCK(rclk), .READ_ENABLE_N(ren_n), .MASTER_RESET_N(mrs_n),
		.FALL_THROUGH_SELECT_SERIAL_IN(fts), .OFFSET_LOAD_N(straps[2]),
		.DEFAULT_OFFSET_SEL1(straps[1]), .DEFAULT_OFFSET_SEL0(straps[0]),
		.DATA_OUT_BUS(dout), .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n),
		.OUTPUT_READY_N(or_n), .INPUT_READY_N(ir_n), .ALMOST_EMPTY_FLAG_N(ae_n),
		.ALMOST_FULL_FLAG_N(af_n), .HALF_FULL_FLAG_N(hf_n), .FALL_THROUGH_MODE(fwm));

	ftsf_partner #(.DW(DW)) ftsf_partner_i (
		.mclk(mclk), .wr_req(wr_req), .rd_req(rd_req), .wdata(wdata),
		.wclk(wclk), .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n), .din(din));

	always #5 mclk = ~mclk;

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			bad_count++;
			finish_test();
		end
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	// Flags {empty, full, out ready, in ready, almost empty, half, almost full}
	function automatic logic [6:0] expf(input int c, input bit f, input int n);
		if (f)
			return {2'h3, c == 0, c >= D + 1, c >= n + 2, c < D / 2 + 2, c < D + 1 - n};
		return {c != 0, c != D, 2'h3, c >= n + 1, c < D / 2 + 1, c < D - n};
	endfunction : expf

	task chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'h1) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task settle;
		repeat (40) @(posedge mclk);
		chk({ef_n, ff_n, or_n, ir_n, ae_n, hf_n, af_n} === expf(cnt, fw, ofs), "flags");
	endtask : settle

	task wr(input logic [DW-1:0] w);
		wr_req <= 1'h1;
		wdata  <= w;
		do @(posedge wclk); while (wen_n !== 1'h0);
		wr_req <= 1'h0;
		if (cnt < D + fw) begin
			q.push_back(w);
			cnt++;
		end
		settle();
		if (fw && cnt == 1)
			chk(dout === q[0], "fall-through word");
	endtask : wr

	task rd;
		logic [DW-1:0] got;
		logic [DW-1:0] want;
		bit            had;
		rd_req <= 1'h1;
		do @(posedge rclk); while (ren_n !== 1'h0);
		rd_req <= 1'h0;
		got = dout;
		had = (cnt > 0);
		if (had) begin
			want = q.pop_front();
			cnt--;
		end
		settle();
		if (!fw)
			got = dout;
		if (had)
			chk(got === want, "read word");
	endtask : rd

	task master_reset_n(input bit f, input logic [2:0] s, input int n);
		mrs_n  <= 1'h0;
		fts    <= f;
		straps <= s;
		repeat (10) @(posedge mclk);
		mrs_n <= 1'h1;
		repeat (10) @(posedge mclk);
		fts    <= !f;
		straps <= ~s;
		fw  = f;
		ofs = n;
		cnt = 0;
		q.delete();
		chk(fwm === f, "mode");
		settle();
	endtask : master_reset_n

	task finish_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		for (int m = 0; m < 2; m++) begin
			master_reset_n(m[0], 3'h0, 127);
			// One write past capacity, one read past empty, then reuse
			for (int i = 0; i <= D + m; i++) begin
				lfsr = next_rand(lfsr);
				wr({lfsr[3:0], lfsr});
			end
			for (int i = 0; i <= D + m; i++)
				rd();
			wr(36'h5a5a5a5a5);
			rd();
		end
		master_reset_n(1'h0, 3'h7, 255);
		wr(36'hf0f0f0f0f);
		finish_test();
	end
endmodule : test_fifo_timing_mode_status_flags
